// *** swt_timer.sv ***
// Purpose: sleep wake-up timer with AXI4-Lite register slave
// Assumes: sleep clock edges arrive as one-cycle ticks synchronous to clk_sys
// Notes:   one read and one write handled at a time
`timescale 1ns/1ps
`include "swt_defines.svh"

module swt_timer
#(
    parameter int CAL_WIDTH = 8
)
(
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire swt_pkg::swt_power_t   power,
    input  wire logic                  xtal32_tick,
    input  wire logic                  rc_tick,
    input  wire logic [CAL_WIDTH-1:0]  cal_result,
    input  wire logic                  cal_valid,
    output logic                       wake,
    output logic                       cpu_sleep_irq_flag,
    output logic                       cal_enable,
    output logic [CAL_WIDTH-1:0]       rc_trim,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    import swt_pkg::*;

    if (CAL_WIDTH < 1 || CAL_WIDTH > 24)
    begin : g_cal_width_check
        $error("CAL_WIDTH out of range");
    end

    // ****************************************
    // state
    // ****************************************
    logic [30:0]  sleep_count;
    logic [1:0]   resolution_select;
    logic [2:0]   ctrl_reserved;
    logic [15:0]  event_timeout_value;
    logic [7:0]   timeout_high_stage;
    logic         event_pending_flag;
    logic         event_irq_mask;
    logic         clock_source_rc;
    logic [15:0]  count_window;
    logic         sleep_mode;
    logic         tick;
    logic         source_running;
    logic         next_event;
    logic         clear_req;

    // ****************************************
    // bus slave
    // ****************************************
    logic         aw_held;
    logic         w_held;
    logic [7:0]   aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         do_write;

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            aw_held       <= 1'b0;
            s_axi_awready <= 1'b0;
            aw_addr       <= 8'h00;
        end
        else if (do_write)
        begin
            aw_held       <= 1'b0;
            s_axi_awready <= 1'b0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held       <= 1'b1;
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            w_held       <= 1'b0;
            s_axi_wready <= 1'b0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
        end
        else if (do_write)
        begin
            w_held       <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
        end
        else
        begin
            s_axi_wready <= !w_held && !s_axi_bvalid;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[7:5] == 3'h0 && aw_addr[1:0] == 2'h0) ? 2'h0 : 2'h2;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // only byte lane 0 carries register data
    logic wr_en;
    assign wr_en = do_write && w_strb[0];

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end
        else if (s_axi_rvalid)
        begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            unique case (s_axi_araddr)
                `SWT_OFF_IRQ:       s_axi_rdata <= {27'h0, event_irq_mask, 3'h0, event_pending_flag};
                // clear bit always reads zero
                `SWT_OFF_CTRL:      s_axi_rdata <= {25'h0, ctrl_reserved, 2'h0, resolution_select};
                `SWT_OFF_TIME_LOW:  s_axi_rdata <= {24'h0, count_window[7:0]};
                `SWT_OFF_TIME_HIGH: s_axi_rdata <= {24'h0, count_window[15:8]};
                `SWT_OFF_TMO_LOW:   s_axi_rdata <= {24'h0, event_timeout_value[7:0]};
                `SWT_OFF_TMO_HIGH:  s_axi_rdata <= {24'h0, timeout_high_stage};
                `SWT_OFF_POWER:     s_axi_rdata <= {27'h0, clock_source_rc, 1'b0, power.mode};
                `SWT_OFF_CAL:       s_axi_rdata <= {{(32-CAL_WIDTH){1'b0}}, rc_trim};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end
        else
        begin
            s_axi_arready <= 1'b1;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            resolution_select <= 2'h0;
            ctrl_reserved     <= `SWT_CTRL_RSV_RST;
            clock_source_rc   <= 1'b0;
            event_irq_mask    <= 1'b0;
        end
        else if (wr_en)
        begin
            if (aw_addr == `SWT_OFF_CTRL)
            begin
                resolution_select <= w_data[`SWT_CTRL_RES_LSB +: 2];
                ctrl_reserved     <= w_data[6:4];
            end
            if (aw_addr == `SWT_OFF_POWER)
                clock_source_rc <= w_data[`SWT_PWR_SRC_BIT];
            if (aw_addr == `SWT_OFF_IRQ)
                event_irq_mask <= w_data[`SWT_IRQ_MASK_BIT];
        end
    end

    assign clear_req = wr_en && aw_addr == `SWT_OFF_CTRL && w_data[`SWT_CTRL_CLR_BIT];

    // high byte staged; low byte write commits the whole word
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            timeout_high_stage  <= `SWT_TMO_HIGH_RST;
            event_timeout_value <= {`SWT_TMO_HIGH_RST, `SWT_TMO_LOW_RST};
        end
        else if (wr_en && aw_addr == `SWT_OFF_TMO_HIGH)
            timeout_high_stage <= w_data[7:0];
        else if (wr_en && aw_addr == `SWT_OFF_TMO_LOW)
            event_timeout_value <= {timeout_high_stage, w_data[7:0]};
    end

    // ****************************************
    // sleep counter
    // ****************************************
    assign sleep_mode     = power.mode == SWT_PM0 || power.mode == SWT_PM1 || power.mode == SWT_PM2;
    assign source_running = clock_source_rc ? power.rc_running : power.xtal32_running;
    assign tick           = clock_source_rc ? rc_tick : xtal32_tick;

    always_ff @(posedge clk_sys)
    begin
        if (rst || !source_running)
            sleep_count <= 31'h0;
        else if (clear_req)
            sleep_count <= `SWT_CLEAR_VALUE;
        else if (next_event)
            sleep_count <= 31'h1; // matching tick opens next period
        else if (tick && sleep_mode)
            sleep_count <= sleep_count + 31'h1;
    end

    // resolution only moves the window
    always_comb
    begin
        unique case (resolution_select)
            2'b00: count_window = sleep_count[15:0];
            2'b01: count_window = sleep_count[20:5];
            2'b10: count_window = sleep_count[25:10];
            2'b11: count_window = sleep_count[30:15];
        endcase
    end

    // window step is 2^(5*res) periods, so mantissa scales
    assign next_event = source_running && sleep_mode && tick
                        && count_window == event_timeout_value
                        && event_timeout_value != 16'h0000;

    // ****************************************
    // event and wake
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst || !source_running)
            event_pending_flag <= 1'b0;
        else if (next_event)
            event_pending_flag <= 1'b1; // set wins over clear
        else if (wr_en && aw_addr == `SWT_OFF_IRQ && !w_data[`SWT_IRQ_FLAG_BIT])
            event_pending_flag <= 1'b0;
    end

    // cpu flag pulses; the cpu keeps its own sticky copy
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cpu_sleep_irq_flag <= 1'b0;
            wake               <= 1'b0;
        end
        else
        begin
            cpu_sleep_irq_flag <= next_event && event_irq_mask;
            wake               <= next_event;
        end
    end

    // ****************************************
    // rc calibration
    // ****************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cal_enable <= 1'b0;
            rc_trim    <= '0;
        end
        else
        begin
            cal_enable <= power.xosc_running && (power.mode == SWT_ACTIVE || power.mode == SWT_PM0);
            // trim frozen outside calibration
            if (cal_enable && cal_valid)
                rc_trim <= cal_result;
        end
    end

endmodule

// *** swt_defines.svh ***
// Purpose: offsets, field positions, reset values and timing counts of the sleep wake-up timer
// Assumes: included by the package-using design file only
// Notes:   byte addresses of 32-bit aligned AXI4-Lite words
`ifndef SWT_DEFINES_SVH
`define SWT_DEFINES_SVH

// ****************************************
// register byte offsets
// ****************************************
`define SWT_OFF_IRQ        8'h00
`define SWT_OFF_CTRL       8'h04
`define SWT_OFF_TIME_LOW   8'h08
`define SWT_OFF_TIME_HIGH  8'h0c
`define SWT_OFF_TMO_LOW    8'h10
`define SWT_OFF_TMO_HIGH   8'h14
`define SWT_OFF_POWER      8'h18
`define SWT_OFF_CAL        8'h1c

// ****************************************
// field positions
// ****************************************
`define SWT_IRQ_FLAG_BIT   0
`define SWT_IRQ_MASK_BIT   4
`define SWT_CTRL_CLR_BIT   2
`define SWT_CTRL_RES_LSB   0
`define SWT_PWR_SRC_BIT    4

// ****************************************
// reset values and counts
// ****************************************
`define SWT_TMO_HIGH_RST   8'h87
`define SWT_TMO_LOW_RST    8'h6b
`define SWT_CTRL_RSV_RST   3'h7
`define SWT_CLEAR_VALUE    31'h0000_0004
`define SWT_RES_STEP       5
`define SWT_RC_DIVIDE      750
`define SWT_XTAL_HZ        32768
`define SWT_SLEEP_MIN      384

`endif

// *** swt_pkg.sv ***
// Purpose: types of the sleep wake-up timer
// Assumes: nothing
// Notes:   power modes as seen by the power mode controller
package swt_pkg;

    typedef enum logic [2:0]
    {
        SWT_ACTIVE = 3'b000,
        SWT_PM0    = 3'b001,
        SWT_PM1    = 3'b010,
        SWT_PM2    = 3'b011,
        SWT_PM3    = 3'b100
    } swt_mode_t;

    typedef struct packed
    {
        logic        xosc_running;
        logic        rc_running;
        logic        xtal32_running;
        swt_mode_t   mode;
    } swt_power_t;

    typedef struct packed
    {
        logic        wake;
        logic        cpu_irq;
    } swt_event_t;

endpackage

// *** swt_power_model.sv ***
// Purpose: power controller and sleep clock sources around the timer
// Assumes: tick periods shortened to keep runs brief
// Notes:   mode is commanded by the bench; sources stop when off
`timescale 1ns/1ps
module swt_power_model
import swt_pkg::*;
#(
    parameter int XT = 8,
    parameter int RC = 6
)
(
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire swt_pkg::swt_mode_t  mode_req,
    input  wire logic                src_on,
    output swt_pkg::swt_power_t      power,
    output logic                     xtal32_tick,
    output logic                     rc_tick,
    output logic [7:0]               cal_result,
    output logic                     cal_valid
);
    int xt_cnt = 0;
    int rc_cnt = 0;
    initial
    begin
        xtal32_tick = 1'b0;
        rc_tick = 1'b0;
        cal_result = 8'h00;
        cal_valid = 1'b0;
    end
    // stopped source gives no ticks at all, not a frozen level
    always @(posedge clk_sys)
    begin
        xt_cnt <= (rst || xt_cnt == XT - 1) ? 0 : xt_cnt + 1;
        rc_cnt <= (rst || rc_cnt == RC - 1) ? 0 : rc_cnt + 1;
        xtal32_tick <= src_on && xt_cnt == XT - 1;
        rc_tick <= src_on && rc_cnt == RC - 1;
        cal_valid <= xt_cnt == 3;
        cal_result <= cal_result + 8'h01;
    end
    // high-speed crystal always runs here
    assign power = '{xosc_running: 1'b1, rc_running: src_on, xtal32_running: src_on, mode: mode_req};
endmodule

// *** swt_timer_asserts.sv ***
// Purpose: port checks of the sleep wake-up timer
// Assumes: ticks are one-cycle pulses
// Notes:   bound to swt_timer
`timescale 1ns/1ps
module swt_timer_asserts
import swt_pkg::*;
#(
    parameter int CAL_WIDTH = 8
)
(
    input wire logic                  clk_sys,
    input wire logic                  rst,
    input wire swt_pkg::swt_power_t   power,
    input wire logic                  xtal32_tick,
    input wire logic                  rc_tick,
    input wire logic                  wake,
    input wire logic                  cpu_sleep_irq_flag,
    input wire logic                  cal_enable,
    input wire logic [CAL_WIDTH-1:0]  rc_trim,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_WAKE_PULSE: assert property (wake |=> !wake)
        else $error("wake wider than one cycle");
    AST_IRQ_WAKE: assert property (cpu_sleep_irq_flag |-> wake)
        else $error("cpu flag without event");
    AST_WAKE_MODE: assert property (wake |-> $past(power.mode) inside {SWT_PM0, SWT_PM1, SWT_PM2})
        else $error("wake outside sleep modes");
    AST_WAKE_TICK: assert property (wake |-> $past(xtal32_tick || rc_tick))
        else $error("wake without sleep tick");
    AST_WAKE_SRC: assert property (wake |-> $past(power.xtal32_running || power.rc_running))
        else $error("wake with source stopped");
    AST_CAL_EN: assert property (1'b1 |=> cal_enable ==
        ($past(power.xosc_running) && $past(power.mode) inside {SWT_ACTIVE, SWT_PM0}))
        else $error("calibration enable wrong");
    AST_TRIM_HOLD: assert property (!$past(rst) && $past(power.mode) inside {SWT_PM1, SWT_PM2}
        && $past(power.mode, 2) inside {SWT_PM1, SWT_PM2} |-> $stable(rc_trim))
        else $error("trim changed in deep sleep");
    AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule

bind swt_timer swt_timer_asserts #(.CAL_WIDTH(CAL_WIDTH)) u_chk (.clk_sys, .rst, .power, .xtal32_tick,
    .rc_tick, .wake, .cpu_sleep_irq_flag, .cal_enable, .rc_trim, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// *** tb_top.sv ***
// Purpose: self-checking bench of the sleep wake-up timer
// Assumes: partner model supplies ticks and power state
// Notes:   tick periods are 8 and 6 clocks
`timescale 1ns/1ps
module tb_top;
    import swt_pkg::*;
    localparam int XT = 8;
    localparam int RC = 6;
    logic        clk_sys, rst, xtal32_tick, rc_tick, cal_valid, src_on;
    logic        wake, cpu_sleep_irq_flag, cal_enable;
    logic [7:0]  cal_result, rc_trim, s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    swt_power_t  power;
    swt_mode_t   mode_req;
    int          errors, tests_run, cyc, nwake, nirq, t_prev, t_last, n0, n;
    logic [1:0]  res_tab [3] = '{2'd0, 2'd1, 2'd2};
    logic [15:0] mant_tab [3] = '{16'd400, 16'd13, 16'd1};
    logic        src_tab [3] = '{1'b0, 1'b1, 1'b0};

    swt_power_model #(.XT(XT), .RC(RC)) u_pm (.clk_sys, .rst, .mode_req, .src_on, .power, .xtal32_tick,
        .rc_tick, .cal_result, .cal_valid);
    swt_timer uut (.clk_sys, .rst, .power, .xtal32_tick, .rc_tick, .cal_result, .cal_valid, .wake,
        .cpu_sleep_irq_flag, .cal_enable, .rc_trim, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // counted off the edge so the main flow never races it
    always @(negedge clk_sys)
    begin
        cyc++;
        nirq += (cpu_sleep_irq_flag === 1'b1);
        if (wake === 1'b1)
        begin
            nwake++;
            t_prev = t_last;
            t_last = cyc;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a);
        chk(d, exp);
    endtask
    task automatic wait_tick(input logic s);
        do @(posedge clk_sys); while ((s ? rc_tick : xtal32_tick) !== 1'b1);
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        print_verdict;
    end
    initial
    begin
        rst = 1'b1;
        src_on = 1'b1;
        mode_req = SWT_ACTIVE;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_wstrb = 4'hf;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rd_chk(8'h14, 32'h87);
        rd_chk(8'h10, 32'h6b);
        rd_chk(8'h04, 32'h70);
        axi_rd(8'h20);
        chk({30'h0, r}, 32'h2);
        axi_wr(8'h20, 32'h0);
        chk({30'h0, r}, 32'h2);
        $display("test reset values done");
        // middle pass runs with the mask off, so the cpu flag must stay quiet there
        for (int i = 0; i < 3; i++)
        begin
            axi_wr(8'h00, {27'h0, i != 1, 4'h0});
            chk({30'h0, r}, 32'h0);
            axi_wr(8'h18, {27'h0, src_tab[i], 4'h0});
            rd_chk(8'h18, {27'h0, src_tab[i], 4'h0});
            axi_wr(8'h04, {30'h0, res_tab[i]});
            axi_wr(8'h04, {29'h0, 1'b1, res_tab[i]});
            repeat (2) wait_tick(src_tab[i]);
            rd_chk(8'h04, {30'h0, res_tab[i]});
            rd_chk(8'h08, 32'(31'h4 >> (5 * res_tab[i])));
            rd_chk(8'h0c, 32'h0);
            wait_tick(src_tab[i]);
            axi_wr(8'h14, {24'h0, mant_tab[i][15:8]});
            axi_wr(8'h10, {24'h0, mant_tab[i][7:0]});
            wait_tick(src_tab[i]);
            mode_req <= SWT_PM2;
            n0 = nwake;
            for (n = 0; nwake < n0 + 2 && n < 30000; n++) @(posedge clk_sys);
            mode_req <= SWT_ACTIVE;
            chk(32'(nwake - n0), 32'h2);
            chk(32'(t_last - t_prev), 32'((int'(mant_tab[i]) << (5 * res_tab[i])) * (src_tab[i] ? RC : XT)));
            $display("test event period %0d done", i);
        end
        rd_chk(8'h00, 32'h11);
        axi_wr(8'h00, 32'h10);
        rd_chk(8'h00, 32'h10);
        chk(32'(nirq), 32'(nwake - 2));
        axi_wr(8'h04, 32'h4);
        axi_wr(8'h04, 32'h3);
        rd_chk(8'h08, 32'h0);
        axi_wr(8'h04, 32'h0);
        rd_chk(8'h08, 32'h4);
        axi_wr(8'h14, 32'h0);
        axi_wr(8'h10, 32'h8);
        for (int j = 0; j < 2; j++)
        begin
            mode_req <= j ? SWT_PM2 : SWT_ACTIVE;
            src_on <= (j == 0);
            n0 = nwake;
            axi_rd(8'h1c);
            repeat (300) @(posedge clk_sys);
            chk(32'(nwake), 32'(n0));
            chk(32'(cal_enable), 32'(j == 0));
            chk(32'(d[7:0] == rc_trim), 32'(j));
            rd_chk(8'h08, j ? 32'h0 : 32'h4);
            $display("test no wake %0d done", j);
        end
        print_verdict;
    end
endmodule
